// ==== core/conv_sched_pkg.sv ====
// constants, register map and state types for the conversion scheduler
package conv_sched_pkg;

    // register offsets (command bytes)
    localparam logic [7:0] OFF_STATUS = 8'h02;
    localparam logic [7:0] OFF_CONFIG = 8'h03;
    localparam logic [7:0] OFF_RATE = 8'h04;
    localparam logic [7:0] OFF_CHAN_EN = 8'h05;
    localparam logic [7:0] OFF_FILTER = 8'h06;
    localparam logic [7:0] OFF_ONESHOT = 8'h0F;

    // field widths and positions
    localparam int RATE_W = 2;
    localparam int NCH = 5;
    localparam int FILT_W = 4;
    localparam int QE_W = 2;
    localparam int CFG_STANDBY_CTL_BIT = 6;
    localparam int STAT_BUSY_BIT = 7;
    localparam int R2F_LSB = 2;

    // reset values
    localparam logic [RATE_W-1:0] RST_RATE = 2'h2;
    localparam logic [NCH-1:0] RST_CHAN_EN = 5'h1F;
    localparam logic [FILT_W-1:0] RST_FILTER = 4'hF;
    localparam logic RST_STANDBY_CTL = 1'b0;
    localparam logic [QE_W-1:0] RST_QE = 2'h3;

    // rate and filter codes
    localparam logic [RATE_W-1:0] RATE_CONT = 2'h0;
    localparam logic [RATE_W-1:0] RATE_FAST = 2'h1;
    localparam logic [RATE_W-1:0] RATE_MID = 2'h2;
    localparam logic [1:0] FILT_OFF = 2'h0;

    // reading low byte masks: fraction bits 4 and 3 only when filtering
    localparam logic [7:0] LSB_MASK_FILT_ON = 8'hF8;
    localparam logic [7:0] LSB_MASK_FILT_OFF = 8'hE0;

    // serial management bus
    localparam logic [6:0] DEV_ADDR = 7'h2A; // arbitrary default address
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // timing
    localparam real CLK_HZ = 250.0e6;
    localparam real RATE_FAST_S = 0.364;
    localparam real RATE_MID_S = 1.0;
    localparam real RATE_SLOW_S = 2.5;
    localparam real SEQ_MIN_S = 0.030;
    localparam real SEQ_MAX_S = 0.143;
    localparam logic [31:0] RATE_FAST_CYC = 32'(RATE_FAST_S * CLK_HZ);
    localparam logic [31:0] RATE_MID_CYC = 32'(RATE_MID_S * CLK_HZ);
    localparam logic [31:0] RATE_SLOW_CYC = 32'(RATE_SLOW_S * CLK_HZ);
    localparam real CHAN_S = (SEQ_MAX_S - SEQ_MIN_S) / (NCH - 1);
    localparam logic [31:0] CHAN_CYC = 32'(CHAN_S * CLK_HZ);
    localparam logic [31:0] SEQ_BASE_CYC = 32'((SEQ_MIN_S - CHAN_S) * CLK_HZ);

    typedef enum logic [3:0] {
        B_IDLE, B_ADDR, B_ADDR_ACK, B_CMD, B_CMD_ACK,
        B_WDATA, B_WDATA_ACK, B_RDATA, B_RDATA_ACK, B_IGNORE
    } bus_st_t;

    typedef enum logic [1:0] {S_STANDBY, S_PREP, S_CONV, S_WAIT} sched_st_t;

endpackage : conv_sched_pkg

// ==== core/sync_ff2.sv ====
// two flip-flop synchroniser, one bit per lane
module sync_ff2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            q <= '1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sync_ff2

// ==== core/temp_conversion_scheduler.sv ====
// conversion scheduler with its serial register slave
module temp_conversion_scheduler #(
    parameter logic [6:0] DEV_ADDR = conv_sched_pkg::DEV_ADDR,
    parameter logic [31:0] RATE_FAST_CYC = conv_sched_pkg::RATE_FAST_CYC,
    parameter logic [31:0] RATE_MID_CYC = conv_sched_pkg::RATE_MID_CYC,
    parameter logic [31:0] RATE_SLOW_CYC = conv_sched_pkg::RATE_SLOW_CYC,
    parameter logic [31:0] CHAN_CYC = conv_sched_pkg::CHAN_CYC,
    parameter logic [31:0] SEQ_BASE_CYC = conv_sched_pkg::SEQ_BASE_CYC
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    input wire logic [7:0] REMOTE1_LSB_RAW,
    input wire logic [7:0] REMOTE2_LSB_RAW,
    output logic [7:0] REMOTE1_LSB,
    output logic [7:0] REMOTE2_LSB,
    output logic [1:0] REMOTE1_FILTER_SEL,
    output logic [1:0] REMOTE2_FILTER_SEL,
    output logic CONV_START,
    output logic [2:0] CONV_CHAN,
    output logic CONV_BUSY
);
    localparam int NCH = conv_sched_pkg::NCH;

    // pin synchronisation and edge detection
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_prev_q;
    logic sda_prev_q;

    sync_ff2 #(.W(2)) u_sync (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .d({SCL, SDA_I}),
        .q(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    wire scl_rise = scl_s && !scl_prev_q;
    wire scl_fall = !scl_s && scl_prev_q;
    wire start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    wire stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // register state
    logic standby_ctl_q;
    logic [conv_sched_pkg::QE_W-1:0] qe_q;
    logic [conv_sched_pkg::RATE_W-1:0] rate_select_q;
    logic [NCH-1:0] chan_en_q;
    logic [conv_sched_pkg::FILT_W-1:0] filter_q;

    // bus engine state
    conv_sched_pkg::bus_st_t bus_q, bus_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic rw_q, rw_d;
    logic drv_q, drv_d;

    // scheduler state
    conv_sched_pkg::sched_st_t sch_q, sch_d;
    logic [31:0] tmr_q, tmr_d;
    logic [31:0] int_q, int_d;
    logic [2:0] chan_q, chan_d;
    logic oneshot_seq_q, oneshot_seq_d;
    logic start_q, start_d;

    wire busy = (sch_q == conv_sched_pkg::S_PREP) || (sch_q == conv_sched_pkg::S_CONV);

    // write decode: a data byte is complete at the fall after its eighth bit
    wire wr_stb = (bus_q == conv_sched_pkg::B_WDATA) && scl_fall && (cnt_q == conv_sched_pkg::BYTE_BITS);
    wire wr_config = wr_stb && (ptr_q == conv_sched_pkg::OFF_CONFIG);
    wire wr_rate = wr_stb && (ptr_q == conv_sched_pkg::OFF_RATE);
    wire wr_chan_en = wr_stb && (ptr_q == conv_sched_pkg::OFF_CHAN_EN);
    wire wr_filter = wr_stb && (ptr_q == conv_sched_pkg::OFF_FILTER);
    // any value triggers; the byte itself is dropped
    wire wr_oneshot = wr_stb && (ptr_q == conv_sched_pkg::OFF_ONESHOT);

    // read mux: reserved bits and the write-only trigger read zero
    wire [7:0] status_rd = 8'({7'h00, busy}) << conv_sched_pkg::STAT_BUSY_BIT;
    wire [7:0] config_rd = (8'({7'h00, standby_ctl_q}) << conv_sched_pkg::CFG_STANDBY_CTL_BIT) | 8'(qe_q);
    wire [7:0] rate_rd = 8'(rate_select_q);
    wire [7:0] chan_en_rd = 8'(chan_en_q);
    wire [7:0] filter_rd = 8'(filter_q);
    wire [7:0] rd_data = (ptr_q == conv_sched_pkg::OFF_STATUS) ? status_rd :
                         (ptr_q == conv_sched_pkg::OFF_CONFIG) ? config_rd :
                         (ptr_q == conv_sched_pkg::OFF_RATE) ? rate_rd :
                         (ptr_q == conv_sched_pkg::OFF_CHAN_EN) ? chan_en_rd :
                         (ptr_q == conv_sched_pkg::OFF_FILTER) ? filter_rd : 8'h00;

    // open drain: only ever pull low
    assign SDA_O = 1'b0;
    assign SDA_OE_N = !drv_q;

    always_comb begin
        bus_d = bus_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        drv_d = drv_q;
        if (start_det) begin
            bus_d = conv_sched_pkg::B_ADDR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
        end else if (stop_det) begin
            bus_d = conv_sched_pkg::B_IDLE;
            drv_d = 1'b0;
        end else begin
            case (bus_q)
                conv_sched_pkg::B_ADDR, conv_sched_pkg::B_CMD, conv_sched_pkg::B_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = 4'(cnt_q + 4'h1);
                    end else if (scl_fall && cnt_q == conv_sched_pkg::BYTE_BITS) begin
                        cnt_d = 4'h0;
                        drv_d = 1'b1;
                        if (bus_q == conv_sched_pkg::B_ADDR) begin
                            rw_d = sh_q[0];
                            bus_d = conv_sched_pkg::B_ADDR_ACK;
                            if (sh_q[7:1] != DEV_ADDR) begin
                                drv_d = 1'b0;
                                bus_d = conv_sched_pkg::B_IGNORE;
                            end
                        end else if (bus_q == conv_sched_pkg::B_CMD) begin
                            ptr_d = sh_q;
                            bus_d = conv_sched_pkg::B_CMD_ACK;
                        end else begin
                            bus_d = conv_sched_pkg::B_WDATA_ACK;
                        end
                    end
                end
                conv_sched_pkg::B_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            sh_d = rd_data;
                            drv_d = !rd_data[7];
                            bus_d = conv_sched_pkg::B_RDATA;
                        end else begin
                            drv_d = 1'b0;
                            bus_d = conv_sched_pkg::B_CMD;
                        end
                    end
                end
                conv_sched_pkg::B_CMD_ACK, conv_sched_pkg::B_WDATA_ACK: begin
                    if (scl_fall) begin
                        drv_d = 1'b0;
                        bus_d = conv_sched_pkg::B_WDATA;
                    end
                end
                conv_sched_pkg::B_RDATA: begin
                    if (scl_fall) begin
                        cnt_d = 4'(cnt_q + 4'h1);
                        if (cnt_q == conv_sched_pkg::LAST_BIT) begin
                            drv_d = 1'b0;
                            bus_d = conv_sched_pkg::B_RDATA_ACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            drv_d = !sh_q[6];
                        end
                    end
                end
                conv_sched_pkg::B_RDATA_ACK: begin
                    if (scl_rise && sda_s) begin
                        bus_d = conv_sched_pkg::B_IGNORE;
                    end else if (scl_fall) begin
                        // pointer does not advance: repeated reads return the same register
                        cnt_d = 4'h0;
                        sh_d = rd_data;
                        drv_d = !rd_data[7];
                        bus_d = conv_sched_pkg::B_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // first enabled channel at or above a start index, NCH when none
    function automatic logic [3:0] next_enabled(input logic [NCH-1:0] en, input logic [3:0] from);
        logic [3:0] r;
        r = 4'(NCH);
        for (int i = NCH - 1; i >= 0; i--) begin
            if (en[i] && 4'(i) >= from) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : next_enabled

    wire [31:0] interval_cyc = (rate_select_q == conv_sched_pkg::RATE_FAST) ? RATE_FAST_CYC :
                               (rate_select_q == conv_sched_pkg::RATE_MID) ? RATE_MID_CYC :
                               RATE_SLOW_CYC;
    wire is_cont = (rate_select_q == conv_sched_pkg::RATE_CONT);
    wire prep_done = (sch_q == conv_sched_pkg::S_PREP) && (tmr_q >= SEQ_BASE_CYC - 32'h1);
    wire chan_done = (sch_q == conv_sched_pkg::S_CONV) && (tmr_q >= CHAN_CYC - 32'h1);
    wire [3:0] from_idx = prep_done ? 4'h0 : 4'(chan_q + 3'h1);
    // the enable mask is read live, so a cleared channel is passed over
    wire [3:0] nxt_ch = next_enabled(chan_en_q, from_idx);
    wire seq_more = (nxt_ch < 4'(NCH));
    wire interval_up = (int_q >= interval_cyc - 32'h1);

    always_comb begin
        sch_d = sch_q;
        tmr_d = 32'(tmr_q + 32'h1);
        int_d = 32'(int_q + 32'h1);
        chan_d = chan_q;
        oneshot_seq_d = oneshot_seq_q;
        start_d = 1'b0;
        case (sch_q)
            conv_sched_pkg::S_STANDBY: begin
                tmr_d = 32'h0;
                int_d = 32'h0;
                if (!standby_ctl_q) begin
                    sch_d = conv_sched_pkg::S_PREP;
                    oneshot_seq_d = 1'b0;
                end else if (wr_oneshot) begin
                    sch_d = conv_sched_pkg::S_PREP;
                    oneshot_seq_d = 1'b1;
                end
            end
            conv_sched_pkg::S_PREP, conv_sched_pkg::S_CONV: begin
                if (prep_done || chan_done) begin
                    tmr_d = 32'h0;
                    if (seq_more) begin
                        sch_d = conv_sched_pkg::S_CONV;
                        chan_d = nxt_ch[2:0];
                        start_d = 1'b1;
                    end else if (oneshot_seq_q || standby_ctl_q) begin
                        sch_d = conv_sched_pkg::S_STANDBY;
                    end else if (is_cont) begin
                        sch_d = conv_sched_pkg::S_PREP;
                        int_d = 32'h0;
                    end else begin
                        sch_d = conv_sched_pkg::S_WAIT;
                    end
                end
            end
            conv_sched_pkg::S_WAIT: begin
                tmr_d = 32'h0;
                if (standby_ctl_q) begin
                    sch_d = conv_sched_pkg::S_STANDBY;
                end else if (interval_up || is_cont) begin
                    // interval counted from sequence start keeps the period fixed
                    sch_d = conv_sched_pkg::S_PREP;
                    int_d = 32'h0;
                end
            end
            default: begin
                sch_d = conv_sched_pkg::S_STANDBY;
            end
        endcase
    end

    // one-shot writes outside standby never reach the scheduler

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            bus_q <= conv_sched_pkg::B_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            bus_q <= bus_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            drv_q <= drv_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            standby_ctl_q <= conv_sched_pkg::RST_STANDBY_CTL;
            qe_q <= conv_sched_pkg::RST_QE;
            rate_select_q <= conv_sched_pkg::RST_RATE;
            chan_en_q <= conv_sched_pkg::RST_CHAN_EN;
            filter_q <= conv_sched_pkg::RST_FILTER;
        end else begin
            if (wr_config) begin
                standby_ctl_q <= sh_q[conv_sched_pkg::CFG_STANDBY_CTL_BIT];
                qe_q <= sh_q[conv_sched_pkg::QE_W-1:0];
            end
            if (wr_rate) begin
                rate_select_q <= sh_q[conv_sched_pkg::RATE_W-1:0];
            end
            if (wr_chan_en) begin
                chan_en_q <= sh_q[NCH-1:0];
            end
            if (wr_filter) begin
                filter_q <= sh_q[conv_sched_pkg::FILT_W-1:0];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sch_q <= conv_sched_pkg::S_STANDBY;
            tmr_q <= 32'h0;
            int_q <= 32'h0;
            chan_q <= 3'h0;
            oneshot_seq_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            sch_q <= sch_d;
            tmr_q <= tmr_d;
            int_q <= int_d;
            chan_q <= chan_d;
            oneshot_seq_q <= oneshot_seq_d;
            start_q <= start_d;
        end
    end

    // filter select fields; reserved code is passed through as written
    assign REMOTE1_FILTER_SEL = filter_q[1:0];
    assign REMOTE2_FILTER_SEL = filter_q[conv_sched_pkg::R2F_LSB +: 2];
    wire [7:0] r1_mask = (REMOTE1_FILTER_SEL == conv_sched_pkg::FILT_OFF) ?
                         conv_sched_pkg::LSB_MASK_FILT_OFF : conv_sched_pkg::LSB_MASK_FILT_ON;
    wire [7:0] r2_mask = (REMOTE2_FILTER_SEL == conv_sched_pkg::FILT_OFF) ?
                         conv_sched_pkg::LSB_MASK_FILT_OFF : conv_sched_pkg::LSB_MASK_FILT_ON;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            REMOTE1_LSB <= 8'h00;
            REMOTE2_LSB <= 8'h00;
        end else begin
            REMOTE1_LSB <= REMOTE1_LSB_RAW & r1_mask;
            REMOTE2_LSB <= REMOTE2_LSB_RAW & r2_mask;
        end
    end

    assign CONV_START = start_q;
    assign CONV_CHAN = chan_q;
    assign CONV_BUSY = busy;

endmodule : temp_conversion_scheduler

// ==== bench/smbus_host_model.sv ====
// serial management bus host driving the scheduler's register port
module smbus_host_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // long low phase: the device lets go of its ack late, so data settles before the rise
    task automatic bit_io(input logic tx, output logic rx);
        #4 sda_rel = tx;
        #16 scl = 1'b1;
        #11 rx = sda;
        #1 scl = 1'b0;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : byte_io
    task automatic start_c;
        sda_rel = 1'b1;
        #20 scl = 1'b1;
        #12 sda_rel = 1'b0;
        #16 scl = 1'b0;
    endtask : start_c
    task automatic stop_c;
        sda_rel = 1'b0;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b1;
        #16;
    endtask : stop_c
    task automatic wr(input logic [7:0] cmd, input logic [7:0] dat, output logic ok);
        logic [7:0] x;
        logic [2:0] k;
        start_c();
        byte_io({ADDR, 1'b0}, x, k[0]);
        byte_io(cmd, x, k[1]);
        byte_io(dat, x, k[2]);
        stop_c();
        ok = &k;
    endtask : wr
    // single-byte read ended by a release, so the device sees a not-acknowledge
    task automatic rd(input logic [7:0] cmd, output logic [7:0] dat);
        logic [7:0] x;
        logic k;
        start_c();
        byte_io({ADDR, 1'b0}, x, k);
        byte_io(cmd, x, k);
        start_c();
        byte_io({ADDR, 1'b1}, x, k);
        byte_io(8'hFF, dat, k);
        stop_c();
    endtask : rd
endmodule : smbus_host_model

// ==== bench/temp_conversion_scheduler_properties.sv ====
// port checker for the conversion scheduler
module conv_sched_props #(
    parameter int CHAN_CYC = 40,
    parameter int SEQ_BASE_CYC = 20
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [7:0] REMOTE1_LSB_RAW,
    input wire logic [7:0] REMOTE2_LSB_RAW,
    input wire logic [7:0] REMOTE1_LSB,
    input wire logic [7:0] REMOTE2_LSB,
    input wire logic [1:0] REMOTE1_FILTER_SEL,
    input wire logic [1:0] REMOTE2_FILTER_SEL,
    input wire logic CONV_START,
    input wire logic [2:0] CONV_CHAN,
    input wire logic CONV_BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);
    // wide enough to saturate above a full-size channel plus overhead time
    logic [31:0] since_q;
    logic [2:0] last_q;
    logic seen_q;
    logic up_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            since_q <= 32'hFFFFFFFF;
            last_q <= 3'h0;
            seen_q <= 1'b0;
            up_q <= 1'b0;
        end else begin
            since_q <= CONV_START ? 32'h1 : since_q + {31'h0, since_q != 32'hFFFFFFFF};
            last_q <= CONV_START ? CONV_CHAN : last_q;
            seen_q <= seen_q | CONV_START;
            up_q <= 1'b1;
        end
    end
    sequence hold_s;
        ($stable(CONV_CHAN) && !CONV_START) [*8];
    endsequence
    sequence prep_s;
        !CONV_START [*8];
    endsequence
    start_busy_a: assert property (CONV_START |-> CONV_BUSY)
        else $error("channel start while not busy");
    chan_range_a: assert property (CONV_START |-> CONV_CHAN <= 3'h4)
        else $error("channel number out of range");
    start_hold_a: assert property (CONV_START |=> hold_s)
        else $error("channel changed inside its conversion");
    prep_gap_a: assert property ($rose(CONV_BUSY) |-> prep_s)
        else $error("channel started without sequence overhead");
    start_gap_a: assert property (CONV_START && seen_q |->
        (since_q == CHAN_CYC && CONV_CHAN > last_q) || since_q >= CHAN_CYC + SEQ_BASE_CYC)
        else $error("channel spacing or order wrong");
    busy_end_a: assert property ($fell(CONV_BUSY) |-> since_q >= CHAN_CYC - 1)
        else $error("busy dropped inside a channel");
    lsb1_mask_a: assert property (up_q |-> REMOTE1_LSB == ($past(REMOTE1_LSB_RAW) &
        ($past(REMOTE1_FILTER_SEL) == 2'h0 ? 8'hE0 : 8'hF8)))
        else $error("remote 1 low byte mask wrong");
    lsb2_mask_a: assert property (up_q |-> REMOTE2_LSB == ($past(REMOTE2_LSB_RAW) &
        ($past(REMOTE2_FILTER_SEL) == 2'h0 ? 8'hE0 : 8'hF8)))
        else $error("remote 2 low byte mask wrong");
endmodule : conv_sched_props
bind temp_conversion_scheduler conv_sched_props #(
    .CHAN_CYC(CHAN_CYC), .SEQ_BASE_CYC(SEQ_BASE_CYC)
) props_i (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .REMOTE1_LSB_RAW(REMOTE1_LSB_RAW),
    .REMOTE2_LSB_RAW(REMOTE2_LSB_RAW), .REMOTE1_LSB(REMOTE1_LSB), .REMOTE2_LSB(REMOTE2_LSB),
    .REMOTE1_FILTER_SEL(REMOTE1_FILTER_SEL), .REMOTE2_FILTER_SEL(REMOTE2_FILTER_SEL),
    .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN), .CONV_BUSY(CONV_BUSY)
);

// ==== bench/temp_conversion_scheduler_tb.sv ====
// self-checking bench for the conversion scheduler
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module temp_conversion_scheduler_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [7:0] cmd;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [2:0] ch;
        logic [11:0] per;
    } row_t;
    // sim counts: intervals 400/600/800, channel 40, overhead 20
    row_t rows [15] = '{'{8'h04, 8'hFF, 8'h03, 3'h0, 12'h000},
        '{8'h05, 8'hFF, 8'h1F, 3'h0, 12'h320}, '{8'h06, 8'hFF, 8'h0F, 3'h0, 12'h000},
        '{8'h06, 8'h0D, 8'h0D, 3'h0, 12'h000}, '{8'h06, 8'h00, 8'h00, 3'h0, 12'h000},
        '{8'h06, 8'h07, 8'h07, 3'h0, 12'h000}, '{8'h0F, 8'hA5, 8'h00, 3'h0, 12'h000},
        '{8'h20, 8'h55, 8'h00, 3'h0, 12'h000}, '{8'h04, 8'h01, 8'h01, 3'h0, 12'h000},
        '{8'h05, 8'h12, 8'h12, 3'h1, 12'h190}, '{8'h04, 8'h02, 8'h02, 3'h1, 12'h258},
        '{8'h04, 8'h00, 8'h00, 3'h1, 12'h064}, '{8'h05, 8'h01, 8'h01, 3'h0, 12'h03C},
        '{8'h05, 8'h1F, 8'h1F, 3'h0, 12'h0DC}, '{8'h02, 8'h00, 8'h80, 3'h0, 12'h000}};
    logic [7:0] rstv [3] = '{8'h02, 8'h1F, 8'h0F};
    logic [7:0] shot [2] = '{8'h00, 8'hFF};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_rel, sda_w, sda_oe_n, busy, start, ok, busy_d;
    logic [7:0] raw1 = 8'h00;
    logic [7:0] raw2 = 8'h00;
    logic [7:0] lsb1, lsb2, d;
    logic [1:0] sel1, sel2;
    logic [2:0] chan;
    logic [4:0] en = 5'h1F;
    logic [4:0] seen;
    logic [11:0] n;
    int n_start, n_busy, s, b, cycles, miscompares, checks_done;
    // open-drain data line with pull-up
    assign sda_w = sda_rel & sda_oe_n;
    always #2 clk = ~clk;
    smbus_host_model #(.ADDR(conv_sched_pkg::DEV_ADDR)) host (.scl(scl), .sda_rel(sda_rel),
        .sda(sda_w));
    temp_conversion_scheduler #(.RATE_FAST_CYC(32'h190), .RATE_MID_CYC(32'h258),
        .RATE_SLOW_CYC(32'h320), .CHAN_CYC(32'h28), .SEQ_BASE_CYC(32'h14)) uut (
        .REF_CLK(clk), .RESETN(rst_n), .SCL(scl), .SDA_I(sda_w), .SDA_O(), .SDA_OE_N(sda_oe_n),
        .REMOTE1_LSB_RAW(raw1), .REMOTE2_LSB_RAW(raw2), .REMOTE1_LSB(lsb1), .REMOTE2_LSB(lsb2),
        .REMOTE1_FILTER_SEL(sel1), .REMOTE2_FILTER_SEL(sel2), .CONV_START(start),
        .CONV_CHAN(chan), .CONV_BUSY(busy));
    always @(negedge clk) begin
        if (start === 1'b1) begin
            n_start++;
            seen[chan] = 1'b1;
        end
        if (busy === 1'b1 && busy_d === 1'b0) n_busy++;
        busy_d = busy;
    end
    task automatic end_sim;
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cycles++;
        if (cycles == 32'h0000EA60) begin
            miscompares++;
            end_sim();
        end
    end
    // cycles up to the next start of channel ch, bounded
    task automatic gap(input logic [2:0] ch, output logic [11:0] cnt);
        cnt = 12'h000;
        do begin
            @(negedge clk);
            cnt++;
        end while (!(start === 1'b1 && chan === ch) && cnt < 12'hFA0);
    endtask : gap
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            raw1 = ~rows[i].wd;
            raw2 = rows[i].wd;
            host.wr(rows[i].cmd, rows[i].wd, ok);
            host.rd(rows[i].cmd, d);
            `CHK("reg", rows[i].rd, d)
            if (rows[i].cmd == 8'h05) en = rows[i].wd[4:0];
            if (rows[i].cmd == 8'h06) begin
                `CHK("sel", rows[i].wd[3:0], {sel2, sel1})
                `CHK("lsb1", raw1 & (rows[i].wd[1:0] == 2'h0 ? 8'hE0 : 8'hF8), lsb1)
                `CHK("lsb2", raw2 & (rows[i].wd[3:2] == 2'h0 ? 8'hE0 : 8'hF8), lsb2)
            end
            if (rows[i].per != 12'h000) begin
                gap(rows[i].ch, n);
                gap(rows[i].ch, n);
                seen = 5'h00;
                gap(rows[i].ch, n);
                seen[rows[i].ch] = 1'b1;
                `CHK("period", rows[i].per, n)
                `CHK("chans", en, seen)
            end
        end
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        `CHK("busy rst", 1'b0, busy)
        `CHK("sel rst", 4'hF, {sel2, sel1})
        rst_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            host.rd(8'h04 + 8'(i), d);
            `CHK("reset val", rstv[i], d)
        end
        host.wr(8'h03, 8'h40, ok);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk);
        s = n_start;
        repeat (1000) @(negedge clk);
        `CHK("standby", s, n_start)
        host.rd(8'h02, d);
        `CHK("status", 8'h00, d)
        foreach (shot[i]) begin
            s = n_start;
            b = n_busy;
            host.wr(8'h0F, shot[i], ok);
            repeat (600) @(negedge clk);
            `CHK("shot chans", s + 5, n_start)
            `CHK("shot runs", b + 1, n_busy)
        end
        // one-shot issued during the wait phase of an active schedule
        host.wr(8'h03, 8'h00, ok);
        host.wr(8'h04, 8'h03, ok);
        gap(3'h0, n);
        gap(3'h0, n);
        repeat (240) @(negedge clk);
        s = n_start;
        host.wr(8'h0F, 8'h3C, ok);
        // a wrongly accepted trigger would show its first channel well inside this wait
        repeat (100) @(negedge clk);
        `CHK("active shot", s, n_start)
        end_sim();
    end
endmodule : temp_conversion_scheduler_tb
